// ==== bench/pinrt_far.sv ====
/*
 Far side model: pin levels, port latches and peripheral outputs.
 Assumes the bench pulses step to move the pattern between checks.
*/
`timescale 1ns/10ps
module pinrt_far (
	input  wire logic clk,
	input  wire logic step,
	output logic [23:0] pin_in,
	output logic [23:0] port_latch_bit,
	output logic [9:1]  periph_out
);
	// Arbitrary start pattern
	initial begin
		pin_in = 24'h5A3C96;
		port_latch_bit = 24'hC3A55E;
		periph_out = 9'h0A6;
	end
	// Pattern moves only on step, so registered pins settle
	always @(posedge clk) begin
		if (step) begin
			pin_in <= ~{pin_in[22:0], pin_in[23]};
			port_latch_bit <= ~port_latch_bit;
			periph_out <= ~{periph_out[8:1], periph_out[9]};
		end
	end
endmodule

// ==== bench/testbench.sv ====
/*
 Self-checking bench for the pin routing block.
 Assumes the strobe register port and the far side model.
*/
`timescale 1ns/10ps
module testbench;
	import pinrt_pkg::*;
	logic clk, rst, por, opt, step, flag;
	logic lk, once;
	pinrt_req_t req;
	logic [7:0] rdata;
	logic [23:0] pin_in, latch;
	logic [9:1] pout;
	logic [N_IN-1:0] pin_rt;
	logic [N_PIN-1:0] pin_out;
	int err_count, total_checks;
	pinrt_top DUT (.clk(clk), .rst(rst), .por(por), .one_shot_lock_option(opt), .req(req),
		.rdata(rdata), .pin_in(pin_in), .port_latch_bit(latch), .periph_out(pout),
		.periph_in(pin_rt), .pin_out(pin_out), .route_lock_flag(flag));
	pinrt_far FAR (.clk(clk), .step(step), .pin_in(pin_in), .port_latch_bit(latch),
		.periph_out(pout));
	// Clock
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
		req <= '{a, d, w, r};
		@(posedge clk);
	endtask
	task automatic idle();
		req <= '0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		acc(a, 8'h00, 1'b0, 1'b1);
		req <= '0;
		#1 cmp(rdata, exp);
		@(posedge clk);
	endtask
	task automatic key(input logic [7:0] v);
		acc(LOCK_OFS, KEY_ONE, 1'b1, 1'b0);
		acc(LOCK_OFS, KEY_TWO, 1'b1, 1'b0);
		acc(LOCK_OFS, v, 1'b1, 1'b0);
		idle();
		// Expected lock state kept by the bench itself
		if (v[0]) begin
			lk = 1'b1;
			once = 1'b1;
		end else if (!(opt && once))
			lk = 1'b0;
		#1 cmp({7'h00, flag}, {7'h00, lk});
		@(posedge clk);
	endtask
	task automatic rs(input logic p);
		por <= p;
		rst <= 1'b1;
		lk = 1'b0;
		once = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_route();
		logic [7:0] v [3] = '{8'h17, 8'h02, 8'h0A};
		foreach (v[i]) begin
			acc(16'h1E00, v[i], 1'b1, 1'b0);
			idle();
			#1 cmp({7'h00, pin_rt[0]}, {7'h00, pin_in[v[i][4:3]*8+v[i][2:0]]});
			@(posedge clk);
		end
		// Two-way signal: input and output routed to the same pin
		acc(IN_OFS[8], 8'h01, 1'b1, 1'b0);
		acc(PIN_OFS[1], 8'h07, 1'b1, 1'b0);
		idle();
		#1 cmp({7'h00, pin_rt[8]}, {7'h00, pin_in[1]});
		@(posedge clk);
		$display("route test done");
	endtask
	task automatic t_src();
		logic [7:0] c [4] = '{8'h01, 8'h09, 8'h3F, 8'h00};
		foreach (c[i]) begin
			acc(16'h1F10, c[i], 1'b1, 1'b0);
			req <= '0;
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
			idle();
			idle();
			#1 cmp({7'h00, pin_out[0]}, {7'h00, c[i] == 1 ? pout[1] : c[i] == 9 ? pout[9] :
				latch[0]});
			@(posedge clk);
		end
		$display("source test done");
	endtask
	task automatic t_lock();
		acc(LOCK_OFS, 8'h01, 1'b1, 1'b0);
		idle();
		#1 cmp({7'h00, flag}, 8'h00);
		@(posedge clk);
		acc(16'h1F10, 8'h09, 1'b1, 1'b0);
		key(8'h01);
		acc(16'h1F10, 8'h05, 1'b1, 1'b0);
		acc(16'h1E00, 8'h11, 1'b1, 1'b0);
		rd(16'h1F10, 8'h09);
		rd(16'h1E00, 8'h0A);
		key(8'h00);
		opt <= 1'b1;
		key(8'h01);
		key(8'h00);
		rs(1'b0);
		#1 cmp({7'h00, flag}, 8'h00);
		@(posedge clk);
		rd(16'h1F10, 8'h09);
		rd(16'h1E00, 8'h0A);
		rs(1'b1);
		rd(16'h1E00, 8'h02);
		rd(16'h1F10, 8'h00);
		$display("lock test done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		por = 1'b1;
		opt = 1'b0;
		step = 1'b0;
		req = '0;
		lk = 1'b0;
		once = 1'b0;
		rs(1'b1);
		rd(16'h1E00, 8'h02);
		rd(16'h1F10, 8'h00);
		rd(16'h0100, 8'h00);
		t_route();
		t_src();
		t_lock();
		close_out();
	end
endmodule

// ==== rtl/pinrt_pkg.sv ====
/*
 Package for the peripheral pin routing block: register offsets, field
 positions, reset values, source codes and the bus carrier struct.
 Assumes a single 10 MHz clock and a plain strobe register port.
*/
package pinrt_pkg;
	localparam int ADDR_W = 16;
	localparam int N_IN   = 13;
	localparam int N_PIN  = 18;
	localparam int N_SRC  = 10;

	// Input route register offsets
	localparam logic [ADDR_W-1:0] IN_OFS [N_IN] = '{
		16'h1E00, 16'h1E90, 16'h1E91, 16'h1E92, 16'h1E9C, 16'h1EA1, 16'h1EA2,
		16'h1EC3, 16'h1EC5, 16'h1EC6, 16'h1EC7, 16'h1ECB, 16'h1ECC};
	// Input route defaults {port,pin}
	localparam logic [4:0] IN_RST [N_IN] = '{
		5'h02, 5'h02, 5'h05, 5'h04, 5'h05, 5'h15, 5'h13,
		5'h12, 5'h10, 5'h11, 5'h13, 5'h15, 5'h14};
	// Pin output source offsets and pin index (port*8+bit)
	localparam logic [ADDR_W-1:0] PIN_OFS [N_PIN] = '{
		16'h1F10, 16'h1F11, 16'h1F12, 16'h1F14, 16'h1F15, 16'h1F1C, 16'h1F1D,
		16'h1F1E, 16'h1F1F, 16'h1F20, 16'h1F21, 16'h1F22, 16'h1F23, 16'h1F24,
		16'h1F25, 16'h1F26, 16'h1F27, 16'h1F28};
	localparam logic [4:0] PIN_IDX [N_PIN] = '{
		5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
		5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h17};
	localparam logic [ADDR_W-1:0] LOCK_OFS = 16'h1E8F;

	// Field positions
	localparam int PORT_LSB = 3;
	localparam int PORT_MSB = 4;
	localparam int PIN_MSB  = 2;
	localparam int SRC_MSB  = 5;
	localparam int LOCK_BIT = 0;

	localparam logic [5:0] SRC_RST  = 6'h00;
	localparam logic [5:0] SRC_LAT  = 6'h00;
	localparam logic [1:0] PORT_MAX = 2'h2;
	localparam logic [7:0] KEY_ONE  = 8'h55;
	localparam logic [7:0] KEY_TWO  = 8'hAA;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} pinrt_req_t;

	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_HALF = 2'b01,
		KEY_OPEN = 2'b10
	} pinrt_key_t;
endpackage

// ==== rtl/pinrt_top.sv ====
/*
 Peripheral pin routing: input route registers, per-pin output source
 registers and the lock register with its key sequence.
 Assumes synchronous pins and a master that never waits.
*/
`timescale 1ns/10ps
module pinrt_top (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       por,
	input  wire logic                       one_shot_lock_option,
	input  wire pinrt_pkg::pinrt_req_t      req,
	output logic [7:0]                      rdata,
	input  wire logic [23:0]                pin_in,
	input  wire logic [23:0]                port_latch_bit,
	input  wire logic [pinrt_pkg::N_SRC-1:1] periph_out,
	output logic [pinrt_pkg::N_IN-1:0]      periph_in,
	output logic [pinrt_pkg::N_PIN-1:0]     pin_out,
	output logic                            route_lock_flag
);
	import pinrt_pkg::*;

	logic [4:0]  in_route_ff [N_IN];
	logic [5:0]  src_ff [N_PIN];
	logic        lock_ff;
	pinrt_key_t  key_ff;
	logic        once_ff;
	logic        route_we;

	// Pin value from a port/pin pair; port D and above reads zero
	function automatic logic pick_pin(input logic [4:0] sel, input logic [23:0] v);
		logic r;
		r = 1'b0;
		if (sel[PORT_MSB:PORT_LSB] <= PORT_MAX)
			r = v[sel];
		return r;
	endfunction

	// Routing writes open only while unlocked
	assign route_we = req.wr && !lock_ff;

	// Input route registers
	always_ff @(posedge clk) begin
		for (int i = 0; i < N_IN; i++) begin
			if (rst && por)
				in_route_ff[i] <= IN_RST[i];
			else if (!rst && route_we && req.addr == IN_OFS[i])
				in_route_ff[i] <= req.wdata[PORT_MSB:0];
		end
	end

	// Pin output source registers
	always_ff @(posedge clk) begin
		for (int i = 0; i < N_PIN; i++) begin
			if (rst && por)
				src_ff[i] <= SRC_RST;
			else if (!rst && route_we && req.addr == PIN_OFS[i])
				src_ff[i] <= req.wdata[SRC_MSB:0];
		end
	end

	// Key sequence tracker; any other access restarts it, but a repeated first key keeps it half open
	always_ff @(posedge clk) begin
		if (rst)
			key_ff <= KEY_IDLE;
		else if (req.wr && req.addr == LOCK_OFS) begin
			unique case (key_ff)
				KEY_IDLE: key_ff <= (req.wdata == KEY_ONE) ? KEY_HALF : KEY_IDLE;
				KEY_HALF: key_ff <= (req.wdata == KEY_TWO) ? KEY_OPEN :
					((req.wdata == KEY_ONE) ? KEY_HALF : KEY_IDLE);
				KEY_OPEN: key_ff <= KEY_IDLE;
				default:  key_ff <= KEY_IDLE;
			endcase
		end else if (req.wr || req.rd)
			key_ff <= KEY_IDLE;
	end

	// Lock flag and one-shot memory
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_ff <= 1'b0;
			once_ff <= 1'b0;
		end else if (req.wr && req.addr == LOCK_OFS && key_ff == KEY_OPEN) begin
			if (req.wdata[LOCK_BIT]) begin
				lock_ff <= 1'b1;
				once_ff <= 1'b1;
			end else if (!(one_shot_lock_option && once_ff))
				lock_ff <= 1'b0;
		end
	end

	// Register readback, one cycle later
	always_ff @(posedge clk) begin
		if (rst)
			rdata <= 8'h00;
		else begin
			rdata <= 8'h00;
			if (req.rd) begin
				for (int i = 0; i < N_IN; i++)
					if (req.addr == IN_OFS[i])
						rdata <= {3'h0, in_route_ff[i]};
				for (int i = 0; i < N_PIN; i++)
					if (req.addr == PIN_OFS[i])
						rdata <= {2'h0, src_ff[i]};
				if (req.addr == LOCK_OFS)
					rdata <= {7'h00, lock_ff};
			end
		end
	end

	// Input routing muxes
	always_comb begin
		for (int i = 0; i < N_IN; i++)
			periph_in[i] = pick_pin(in_route_ff[i], pin_in);
	end

	// Output routing muxes, unknown codes fall back to the latch
	always_ff @(posedge clk) begin
		for (int i = 0; i < N_PIN; i++) begin
			if (src_ff[i] != SRC_LAT && src_ff[i] < 6'(N_SRC))
				pin_out[i] <= periph_out[src_ff[i][3:0]];
			else
				pin_out[i] <= port_latch_bit[PIN_IDX[i]];
		end
	end

	assign route_lock_flag = lock_ff;

	// Checks
	locked_write_a: assert property (@(posedge clk) disable iff (rst)
		lock_ff && req.wr && req.addr == IN_OFS[0] |=> $stable(in_route_ff[0]))
		else $error("routing changed while locked");
	open_write_a: assert property (@(posedge clk) disable iff (rst)
		!lock_ff && req.wr && req.addr == PIN_OFS[0] |=> src_ff[0] == $past(req.wdata[5:0]))
		else $error("unlocked write lost");
	por_src_a: assert property (@(posedge clk) rst && por |=> src_ff[3] == SRC_RST)
		else $error("source not cleared");
	por_in_a: assert property (@(posedge clk) rst && por |=> in_route_ff[5] == IN_RST[5])
		else $error("input default wrong");
	warm_keep_a: assert property (@(posedge clk) rst && !por |=> $stable(src_ff[1]))
		else $error("warm reset changed source");
	lock_clear_a: assert property (@(posedge clk) rst |=> !lock_ff)
		else $error("lock survived reset");
	no_key_a: assert property (@(posedge clk) disable iff (rst)
		key_ff != KEY_OPEN |=> lock_ff == $past(lock_ff))
		else $error("lock moved without key");
	one_shot_a: assert property (@(posedge clk) disable iff (rst)
		one_shot_lock_option && once_ff && lock_ff |=> lock_ff)
		else $error("one-shot lock cleared");
	mux_in_a: assert property (@(posedge clk) disable iff (rst)
		in_route_ff[1][4:3] <= PORT_MAX |-> periph_in[1] == pin_in[in_route_ff[1]])
		else $error("input mux wrong");
	cov_lock_c: cover property (@(posedge clk) $rose(lock_ff));
	cov_unlock_c: cover property (@(posedge clk) $fell(lock_ff) && !rst);
	cov_blocked_c: cover property (@(posedge clk) lock_ff && req.wr && req.addr == PIN_OFS[2]);
endmodule
